/* File: shared/spc_pkg.sv */
// spc_pkg: constants, register map and carrier types for the stepper phase chopper.
// assumes a single 10 MHz system clock.
package spc_pkg;
   localparam int unsigned CLK_MHZ         = 10;
   // times in nanoseconds, as printed
   localparam int unsigned DEAD_TIME_NS    = 300;
   localparam int unsigned DEAD_MAX_NS     = 1000;
   localparam int unsigned OFF_PERIOD_NS   = 64000;
   localparam int unsigned BLANK_NS        = 500;
   localparam int unsigned CLK_PERIOD_NS   = 1000 / CLK_MHZ;
   // least times round up
   localparam int unsigned DEAD_CYC        = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned OFF_CYC         = (OFF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned BLANK_CYC       = (BLANK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned CNT_W           = 12;

   // register byte offsets
   localparam logic [3:0] CTRL_OFFSET      = 4'h0;
   localparam logic [3:0] STATUS_OFFSET    = 4'h4;
   localparam logic [3:0] DEAD_OFFSET      = 4'h8;
   localparam logic [3:0] OFFP_OFFSET      = 4'hC;
   // control fields
   localparam int unsigned CTRL_SYNC_BIT   = 0;
   localparam logic        CTRL_RESET      = 1'b0;
   // status fields
   localparam int unsigned ST_CHOP_BIT     = 0;
   localparam int unsigned ST_DEAD_BIT     = 1;
   localparam int unsigned ST_OFF_BIT      = 2;
   localparam int unsigned ST_OC_BIT       = 3;
   localparam int unsigned ST_EN_BIT       = 4;
   localparam int unsigned ST_PH_BIT       = 5;
   localparam logic [1:0] RESP_OKAY        = 2'h0;
   localparam logic [1:0] RESP_SLVERR      = 2'h2;

   typedef struct packed {
      logic highSideASwitch;
      logic highSideBSwitch;
      logic lowSideASwitch;
      logic lowSideBSwitch;
   } spc_switch_type;

   typedef enum logic [2:0] {
      PH_OFF  = 3'h1,
      PH_DEAD = 3'h2,
      PH_RUN  = 3'h4
   } spc_bridge_type;
endpackage

/* File: logic/spc_cycle_timer.sv */
// spc_cycle_timer: loadable down counter with a one-cycle done pulse.
// assumes load and the count value come from the same clock domain.
`timescale 1ns/1ns
module spc_cycle_timer
   import spc_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic             load,
   input  wire logic [CNT_W-1:0] count,
   output logic                  busy,
   output logic                  done
);
   logic [CNT_W-1:0] count_reg;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         count_reg <= '0;
      end else if (load) begin
         count_reg <= count;
      end else if (count_reg != '0) begin
         count_reg <= count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         done <= 1'b0;
      end else begin
         done <= !load && (count_reg == {{(CNT_W-1){1'b0}}, 1'b1});
      end
   end

   assign busy = (count_reg != '0);
endmodule

/* File: logic/spc_chopper.sv */
// spc_chopper: enable/phase bridge steering, dead time and current chopper for one winding.
// assumes overCurrent and syncIn are asynchronous pins; registers over AXI4-Lite.
// How it works
// - enable low turns all four switches off
// - floating enable reads low, outputs off
// - enable high lets selected sink conduct
// - phase low: output a sinks, b sources
// - phase high: output b sinks, a sources
// - only low side chopped; high side stays
// - dead time holds switches off at phase change
// - over-current turns the active sink off
// - sync mode or free-running timer mode
// - free-run trip clears flop, starts off timer
// - sinks stay off for whole off period
// - off-period end pulse retries if current low
// - each free-run trip reloads the off timer
// - timer starts charged after reset
// - switch table per enable and phase
// - sync falling edge sets flop if current low
// - short over-current pulses are blanked out
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ns
module spc_chopper
   import spc_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       enableIn,
   input  wire logic       phaseIn,
   input  wire logic       syncIn,
   input  wire logic       overCurrent,
   output spc_switch_type  switches,
   output logic            bridgeOutA,
   output logic            bridgeOutB,
   output logic            standby,
   input  wire logic [3:0] s_axi_awaddr,
   input  wire logic       s_axi_awvalid,
   output logic            s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0] s_axi_wstrb,
   input  wire logic       s_axi_wvalid,
   output logic            s_axi_wready,
   output logic [1:0]      s_axi_bresp,
   output logic            s_axi_bvalid,
   input  wire logic       s_axi_bready,
   input  wire logic [3:0] s_axi_araddr,
   input  wire logic       s_axi_arvalid,
   output logic            s_axi_arready,
   output logic [31:0]     s_axi_rdata,
   output logic [1:0]      s_axi_rresp,
   output logic            s_axi_rvalid,
   input  wire logic       s_axi_rready
);
   // input synchronisers: first stage read only by second
   logic [1:0] enSync_reg, phSync_reg, syncSync_reg, ocSync_reg;
   logic       syncPrev_reg;
   logic       enSafe, phSafe, ocSafe, syncFall;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         enSync_reg   <= 2'h0;
         phSync_reg   <= 2'h0;
         syncSync_reg <= 2'h3;
         ocSync_reg   <= 2'h0;
         syncPrev_reg <= 1'b1;
      end else begin
         enSync_reg   <= {enSync_reg[0], enableIn};
         phSync_reg   <= {phSync_reg[0], phaseIn};
         syncSync_reg <= {syncSync_reg[0], syncIn};
         ocSync_reg   <= {ocSync_reg[0], overCurrent};
         syncPrev_reg <= syncSync_reg[1];
      end
   end

   // an unknown enable from an open pin counts as low
   assign enSafe   = (enSync_reg[1] === 1'b1);
   assign phSafe   = phSync_reg[1];
   assign ocSafe   = ocSync_reg[1];
   assign syncFall = syncPrev_reg && !syncSync_reg[1];

   // registers
   logic             syncMode_reg;
   logic [CNT_W-1:0] deadCyc_reg, offCyc_reg;

   // blanking: over-current must persist past the blank time to count
   logic [CNT_W-1:0] blank_reg;
   logic             ocQual;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         blank_reg <= '0;
      end else if (!ocSafe) begin
         blank_reg <= '0;
      end else if (blank_reg != CNT_W'(BLANK_CYC)) begin
         blank_reg <= blank_reg + 1'b1;
      end
   end
   assign ocQual = ocSafe && (blank_reg == CNT_W'(BLANK_CYC));

   // bridge state: off, dead time, running
   spc_bridge_type bridge_reg, bridge_next;
   logic           phaseHeld_reg;
   logic           deadLoad, deadBusy, deadDone;

   spc_cycle_timer deadTimer (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (deadLoad),
      .count   (deadCyc_reg),
      .busy    (deadBusy),
      .done    (deadDone)
   );

   assign deadLoad = enSafe && ((bridge_reg == PH_OFF) ||
                     (bridge_reg == PH_RUN && phSafe != phaseHeld_reg));

   always_comb begin
      bridge_next = bridge_reg;
      case (bridge_reg)
         PH_OFF:  if (enSafe) bridge_next = PH_DEAD;
         PH_DEAD: if (!enSafe) bridge_next = PH_OFF;
                  else if (deadDone || (!deadBusy && !deadLoad)) bridge_next = PH_RUN;
         PH_RUN:  if (!enSafe) bridge_next = PH_OFF;
                  else if (phSafe != phaseHeld_reg) bridge_next = PH_DEAD;
         default: bridge_next = PH_OFF;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bridge_reg    <= PH_OFF;
         phaseHeld_reg <= 1'b0;
      end else begin
         bridge_reg <= bridge_next;
         if (deadLoad) begin
            phaseHeld_reg <= phSafe;
         end
      end
   end

   // chopper: state flop plus off-period timer
   logic chopOn_reg;
   logic offLoad, offBusy, offDone;
   logic tripNow, retry;

   spc_cycle_timer offPeriodTimer (
      .clk     (clk),
      .reset_n (reset_n),
      .load    (offLoad),
      .count   (offCyc_reg),
      .busy    (offBusy),
      .done    (offDone)
   );

   assign tripNow = chopOn_reg && ocQual;
   // free-run: timer is loaded on the trip; end pulse retries once
   assign offLoad = !syncMode_reg && tripNow;
   assign retry   = syncMode_reg ? syncFall : offDone;

   // reset leaves the timer idle (charged): first trip starts a full period
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chopOn_reg <= 1'b1;
      end else if (tripNow) begin
         chopOn_reg <= 1'b0;
      end else if (!chopOn_reg && retry && !ocSafe && !offBusy) begin
         chopOn_reg <= 1'b1;
      end else if (!chopOn_reg && !syncMode_reg && !offBusy && !offDone && !ocSafe) begin
         // mode switched to free-run while off: recover without a pulse
         chopOn_reg <= 1'b1;
      end
   end

   // switch drive
   logic running, driveOn;
   assign running = (bridge_reg == PH_RUN);
   // enable low cuts the drive on the edge it is seen, not one state later
   assign driveOn = running && enSafe;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         switches   <= '0;
         bridgeOutA <= 1'b0;
         bridgeOutB <= 1'b0;
         standby    <= 1'b1;
      end else begin
         standby                  <= !enSafe;
         switches.highSideASwitch <= driveOn && phaseHeld_reg;
         switches.highSideBSwitch <= driveOn && !phaseHeld_reg;
         switches.lowSideASwitch  <= driveOn && !phaseHeld_reg && chopOn_reg && !tripNow;
         switches.lowSideBSwitch  <= driveOn && phaseHeld_reg && chopOn_reg && !tripNow;
         bridgeOutA <= driveOn && phaseHeld_reg;
         bridgeOutB <= driveOn && !phaseHeld_reg;
      end
   end

   // AXI4-Lite slave, one write and one read at a time
   logic [3:0]  awAddr_reg;
   logic        awHave_reg, wHave_reg;
   logic [31:0] wData_reg;
   // strobes are only valid beside wvalid, so they are held with the data
   logic [3:0]  wStrb_reg;

   assign s_axi_awready = !awHave_reg && !s_axi_bvalid;
   assign s_axi_wready  = !wHave_reg && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         awHave_reg   <= 1'b0;
         wHave_reg    <= 1'b0;
         awAddr_reg   <= 4'h0;
         wData_reg    <= 32'h0;
         wStrb_reg    <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awHave_reg <= 1'b1;
            awAddr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHave_reg <= 1'b1;
            wData_reg <= s_axi_wdata;
            wStrb_reg <= s_axi_wstrb;
         end
         if (awHave_reg && wHave_reg) begin
            awHave_reg   <= 1'b0;
            wHave_reg    <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (awAddr_reg[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         syncMode_reg <= CTRL_RESET;
         deadCyc_reg  <= CNT_W'(DEAD_CYC);
         offCyc_reg   <= CNT_W'(OFF_CYC);
      end else if (awHave_reg && wHave_reg && wStrb_reg[0]) begin
         case (awAddr_reg)
            CTRL_OFFSET: syncMode_reg <= wData_reg[CTRL_SYNC_BIT];
            DEAD_OFFSET: deadCyc_reg  <= (wData_reg[CNT_W-1:0] == '0) ? CNT_W'(1)
                                         : wData_reg[CNT_W-1:0];
            OFFP_OFFSET: offCyc_reg   <= (wData_reg[CNT_W-1:0] == '0) ? CNT_W'(1)
                                         : wData_reg[CNT_W-1:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp  <= RESP_OKAY;
         case (s_axi_araddr)
            CTRL_OFFSET:   s_axi_rdata <= {31'h0, syncMode_reg};
            STATUS_OFFSET: s_axi_rdata <= {26'h0, phaseHeld_reg, enSafe, ocQual,
                                           offBusy, bridge_reg == PH_DEAD, chopOn_reg};
            DEAD_OFFSET:   s_axi_rdata <= {20'h0, deadCyc_reg};
            OFFP_OFFSET:   s_axi_rdata <= {20'h0, offCyc_reg};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= RESP_SLVERR;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // assertions
   standby_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      !enSafe |=> (switches == '0)) else $error("switches on while disabled");
   no_shoot_a: assert property (@(posedge clk) disable iff (!reset_n)
      !(switches.highSideASwitch && switches.lowSideASwitch) &&
      !(switches.highSideBSwitch && switches.lowSideBSwitch))
      else $error("shoot-through on one leg");
   dead_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
      (running && phSafe != phaseHeld_reg && enSafe) |=> !running [*2])
      else $error("dead time skipped");
   trip_off_a: assert property (@(posedge clk) disable iff (!reset_n)
      tripNow |=> !switches.lowSideASwitch && !switches.lowSideBSwitch)
      else $error("sink left on after trip");
   high_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (running && $past(running) && enSafe && tripNow) |=>
      (switches.highSideASwitch || switches.highSideBSwitch))
      else $error("high side chopped");
   off_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (offLoad && !syncMode_reg) |=> !chopOn_reg [*8])
      else $error("early retry in off period");
   retry_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
      ($rose(chopOn_reg)) |-> !$past(ocSafe)) else $error("retry with high current");
   blank_a: assert property (@(posedge clk) disable iff (!reset_n)
      $rose(ocSafe) |-> !ocQual [*5]) else $error("short pulse not blanked");
   phase_map_a: assert property (@(posedge clk) disable iff (!reset_n)
      driveOn |=> (bridgeOutA == $past(phaseHeld_reg)) && (bridgeOutB == !$past(phaseHeld_reg)))
      else $error("phase map wrong");
   sync_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
      (syncMode_reg && !syncFall && !chopOn_reg) |=> !chopOn_reg)
      else $error("sync mode turned on without an edge");
endmodule

/* File: test/spc_mcu_model.sv */
// spc_mcu_model: microcontroller side that drives the enable, phase and sync pins.
// assumes one clock; every pin changes just after a rising edge.
`timescale 1ns/1ns
module spc_mcu_model #(
   parameter int unsigned SYNC_LOW = 20
)
(
   input  wire logic clk,
   input  wire logic wantEnable,
   input  wire logic floatEnable,
   input  wire logic wantPhase,
   input  wire logic syncReq,
   output logic      enableIn,
   output logic      phaseIn,
   output logic      syncIn
);
   int unsigned syncCnt = 0;
   initial begin
      enableIn = 1'bz;
      phaseIn  = 1'b0;
      syncIn   = 1'b1;
   end
   // an open enable pin floats; the device must read it as low
   always @(posedge clk) begin
      enableIn <= floatEnable ? 1'bz : wantEnable;
      phaseIn  <= wantPhase;
   end
   // sync idles high; a request gives one falling edge, long low keeps the duty sane
   always @(posedge clk) begin
      if (syncCnt != 0) begin
         syncCnt <= syncCnt - 1;
         syncIn  <= (syncCnt == 1);
      end else if (syncReq) begin
         syncIn  <= 1'b0;
         syncCnt <= SYNC_LOW;
      end
   end
endmodule

/* File: test/spc_chopper_tb_top.sv */
// spc_chopper_tb_top: self-checking bench for the stepper phase chopper.
// assumes the mcu model drives the pins and the bench plays the current comparator.
`timescale 1ns/1ns
module spc_chopper_tb_top
   import spc_pkg::*;
;
   logic clk = 1'b0, reset_n = 1'b0, overCurrent = 1'b0;
   logic wantEnable = 1'b0, floatEnable = 1'b1, wantPhase = 1'b0, syncReq = 1'b0;
   wire            enableIn, phaseIn, syncIn;
   spc_switch_type switches;
   logic           bridgeOutA, bridgeOutB, standby;
   logic [3:0]     s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
   logic [31:0]    s_axi_wdata = 32'h0, s_axi_rdata;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]     s_axi_bresp, s_axi_rresp;
   int             miscompares = 0, compares = 0, n;
   localparam logic [31:0] OFF_SIM = 32'h14;

   spc_mcu_model i_mcu (.clk(clk), .wantEnable(wantEnable), .floatEnable(floatEnable),
      .wantPhase(wantPhase), .syncReq(syncReq), .enableIn(enableIn), .phaseIn(phaseIn),
      .syncIn(syncIn));
   spc_chopper i_dut (.clk(clk), .reset_n(reset_n), .enableIn(enableIn), .phaseIn(phaseIn),
      .syncIn(syncIn), .overCurrent(overCurrent), .switches(switches),
      .bridgeOutA(bridgeOutA), .bridgeOutB(bridgeOutB), .standby(standby),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

   initial begin
      forever #50 clk = ~clk;
   end

   task automatic test_done;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // ready is read at the falling edge: it is what the next rising edge samples
   task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
      logic awHit, wHit, bDone;
      bDone = 1'b0;
      @(posedge clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hF;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!bDone) begin
         @(negedge clk);
         awHit = s_axi_awvalid & s_axi_awready;
         wHit = s_axi_wvalid & s_axi_wready;
         bDone = s_axi_bvalid;
         r = s_axi_bresp;
         @(posedge clk);
         if (awHit) s_axi_awvalid <= 1'b0;
         if (wHit) s_axi_wvalid <= 1'b0;
      end
      s_axi_bready <= 1'b0;
   endtask

   task automatic axiRead(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      logic arHit, rDone;
      rDone = 1'b0;
      @(posedge clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      while (!rDone) begin
         @(negedge clk);
         arHit = s_axi_arvalid & s_axi_arready;
         rDone = s_axi_rvalid;
         d = s_axi_rdata;
         r = s_axi_rresp;
         @(posedge clk);
         if (arHit) s_axi_arvalid <= 1'b0;
      end
      s_axi_rready <= 1'b0;
   endtask

   task automatic regCheck(input string what, input logic [3:0] a, input logic [31:0] mask,
                           input logic [31:0] exp, input logic [1:0] expResp);
      logic [31:0] d;
      logic [1:0]  r;
      axiRead(a, d, r);
      check(what, d & mask, exp);
      check("read response", r, expResp);
   endtask

   // returns at a falling edge with the count of extra edges waited
   task automatic waitSw(input logic [3:0] exp, input int lim, output int cnt);
      cnt = 0;
      @(negedge clk);
      while (switches !== exp && cnt < lim) begin
         @(negedge clk);
         cnt++;
      end
   endtask

   task automatic tReset;
      logic [1:0] r;
      @(negedge clk);
      check("standby", standby, 1'b1);
      check("switches", switches, 4'h0);
      regCheck("ctrl", CTRL_OFFSET, 32'hFFFF_FFFF, 32'h0, RESP_OKAY);
      regCheck("dead", DEAD_OFFSET, 32'hFFFF_FFFF, DEAD_CYC, RESP_OKAY);
      regCheck("off", OFFP_OFFSET, 32'hFFFF_FFFF, OFF_CYC, RESP_OKAY);
      regCheck("unmapped", 4'h2, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
      axiWrite(4'h2, 32'h1, r);
      check("misaligned write", r, RESP_SLVERR);
      axiWrite(DEAD_OFFSET, 32'h0, r);
      check("write response", r, RESP_OKAY);
      regCheck("dead floor", DEAD_OFFSET, 32'hFFFF_FFFF, 32'h1, RESP_OKAY);
      axiWrite(DEAD_OFFSET, DEAD_CYC, r);
   endtask

   task automatic tEnable;
      @(posedge clk);
      floatEnable <= 1'b0;
      wantEnable <= 1'b1;
      waitSw(4'h6, 20, n);
      check("phase low switches", switches, 4'h6);
      check("dead after enable", n >= DEAD_CYC, 1'b1);
      check("a sinks", {bridgeOutA, bridgeOutB}, 2'h1);
      check("standby off", standby, 1'b0);
      regCheck("status", STATUS_OFFSET, 32'h31, 32'h11, RESP_OKAY);
   endtask

   task automatic tPhase;
      @(posedge clk);
      wantPhase <= 1'b1;
      waitSw(4'h0, 8, n);
      check("gap at change", switches, 4'h0);
      waitSw(4'h9, 20, n);
      check("phase high switches", switches, 4'h9);
      check("dead span", n >= DEAD_CYC - 1 && n <= 10, 1'b1);
      check("b sinks", {bridgeOutA, bridgeOutB}, 2'h2);
   endtask

   // a 3-cycle spike is under the blanking span and must not chop
   task automatic tBlank;
      @(posedge clk);
      overCurrent <= 1'b1;
      repeat (3) @(posedge clk);
      overCurrent <= 1'b0;
      waitSw(4'h8, 15, n);
      check("spike ignored", n, 15);
   endtask

   task automatic tFreeRun;
      logic [1:0] r;
      axiWrite(OFFP_OFFSET, OFF_SIM, r);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk);
         overCurrent <= 1'b1;
         waitSw(4'h8, 20, n);
         check("trip keeps high side", switches, 4'h8);
         @(posedge clk);
         overCurrent <= 1'b0;
         waitSw(4'h9, 40, n);
         check("off period", n >= OFF_SIM - 1 && n <= OFF_SIM + 5, 1'b1);
      end
   endtask

   task automatic tSync;
      logic [1:0] r;
      axiWrite(CTRL_OFFSET, 32'h1, r);
      @(posedge clk);
      overCurrent <= 1'b1;
      waitSw(4'h8, 20, n);
      check("sync trip", switches, 4'h8);
      regCheck("sync status", STATUS_OFFSET, 32'h0F, 32'h08, RESP_OKAY);
      @(posedge clk);
      overCurrent <= 1'b0;
      waitSw(4'h9, 40, n);
      check("no timer retry", n, 40);
      @(posedge clk);
      overCurrent <= 1'b1;
      syncReq <= 1'b1;
      @(posedge clk);
      syncReq <= 1'b0;
      waitSw(4'h9, 30, n);
      check("edge refused", n, 30);
      @(posedge clk);
      overCurrent <= 1'b0;
      repeat (8) @(posedge clk);
      syncReq <= 1'b1;
      @(posedge clk);
      syncReq <= 1'b0;
      waitSw(4'h9, 15, n);
      check("edge retries", n < 15, 1'b1);
   endtask

   task automatic tDisable;
      @(posedge clk);
      wantEnable <= 1'b0;
      waitSw(4'h0, 10, n);
      check("disabled", {switches, bridgeOutA, bridgeOutB, standby}, 7'h01);
      @(posedge clk);
      wantEnable <= 1'b1;
      repeat (10) @(negedge clk);
      check("enabled", standby, 1'b0);
      @(posedge clk);
      floatEnable <= 1'b1;
      repeat (6) @(negedge clk);
      check("floating", {switches, standby}, 5'h01);
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      $display("Error watchdog expected finish seen hang");
      test_done();
   end

   initial begin
      repeat (8) @(posedge clk);
      reset_n <= 1'b1;
      tReset();
      tEnable();
      tPhase();
      tBlank();
      tFreeRun();
      tSync();
      tDisable();
      test_done();
   end
endmodule
